// ===== hdl/ias_pkg.sv
// Constants and register map for the incremental converter sequencer
// Behaviour
// - Result is 16-bit two's complement ratio
// - Full scale codes 8000 and 7fff
// - Out-of-range results clamp, never wrap
// - Below 16 bits: pad one, then zeros
// - High byte sign and upper bits, low rest
// - Request runs one conversion then idles
// - Continuous mode re-requests after each completion
// - Continuous results refresh at constant rate
// - Init, elementary conversions, termination, then average
// - Elementary count is two to exponent
// - Samples per elementary is eight shifted exponent
// - Elementary conversions alternate direct and crossed
// - Elementary conversion accumulates modulator output
// - Time is count times samples+1 plus overhead
// - Init at most five, termination four-five
// - Resolution six+2osr+count exponent, capped sixteen
// - Start bit begins conversion after settling
// - Busy rises after request, falls at result
// - Sample clock is peripheral clock over four
package ias_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_SETUP_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RESULT_LOW = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam int BIT_START = 7;
  localparam int POS_NEL = 5;
  localparam int POS_OSR = 2;
  localparam int BIT_CONT = 1;
  localparam int BIT_BUSY = 0;
  localparam int BIT_BAD_CFG = 1;
  localparam int OSR_W = 3;
  localparam int NEL_W = 2;
  localparam logic [OSR_W-1:0] OSR_RESET = 3'h0;
  localparam logic [NEL_W-1:0] NEL_RESET = 2'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CODE_NEG_FS = 16'h8000;
  localparam logic [15:0] CODE_POS_FS = 16'h7fff;
  localparam int SAMPLE_DIV = 4;
  localparam int SMAX_BASE_LOG = 3;
  localparam int RES_BASE = 6;
  localparam int RES_MAX = 16;
  localparam int N_INIT = 5;
  localparam int N_END = 4;
  localparam int SUM_W = 16;
  localparam int CNT_W = 11;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INIT = 2'b01,
    ST_CONV = 2'b10,
    ST_TERM = 2'b11
  } ias_state_t;
endpackage : ias_pkg

// ===== hdl/ias_result_format.sv
// Averaging, saturation and left-aligned normalisation of the result word
`timescale 1ns/100ps
module ias_result_format
(
  input wire logic signed [ias_pkg::SUM_W-1:0] sumVal,
  input wire logic [ias_pkg::OSR_W-1:0] osrExp,
  input wire logic [ias_pkg::NEL_W-1:0] nelExp,
  output logic [15:0] code
);
  logic signed [31:0] scaled;
  logic [4:0] shiftAmt;
  logic [4:0] resBits;
  logic [15:0] satCode;

  always_comb
  begin
    // Average over all samples is a shift: full scale count maps to 2^15
    shiftAmt = 5'(12 - int'(osrExp) - int'(nelExp));
    scaled = 32'(sumVal) <<< shiftAmt;
    resBits = 5'(ias_pkg::RES_BASE + 2 * int'(osrExp) + int'(nelExp));
    if (resBits > 5'(ias_pkg::RES_MAX))
      resBits = 5'(ias_pkg::RES_MAX);
    if (scaled > 32'sd32767)
      satCode = ias_pkg::CODE_POS_FS;
    else if (scaled < -32'sd32768)
      satCode = ias_pkg::CODE_NEG_FS;
    else
      satCode = scaled[15:0];
    for (int i = 0; i < 16; i++)
    begin
      if (i > 15 - int'(resBits))
        code[i] = satCode[i];
      else if (i == 15 - int'(resBits))
        code[i] = 1'b1;
      else
        code[i] = 1'b0;
    end
  end
endmodule : ias_result_format

// ===== hdl/ias_sequencer.sv
// Incremental converter sequencer with APB register slave
`timescale 1ns/100ps
module ias_sequencer
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ias_pkg::ADDR_W-1:0] paddr,
  input wire logic [ias_pkg::DATA_W-1:0] pwdata,
  output logic [ias_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic modBit,
  output logic modRun,
  output logic modClear,
  output logic crossInputs,
  output logic busy
);
  localparam int CNT_W = ias_pkg::CNT_W;
  ias_pkg::ias_state_t state_ff;
  ias_pkg::ias_state_t nxt_state;
  logic [1:0] divCnt_ff;
  logic sampleTick;
  logic modSync1_ff;
  logic modSync2_ff;
  logic contBit_ff;
  logic [ias_pkg::OSR_W-1:0] osrCfg_ff;
  logic [ias_pkg::NEL_W-1:0] nelCfg_ff;
  logic [ias_pkg::OSR_W-1:0] osrRun_ff;
  logic [ias_pkg::NEL_W-1:0] nelRun_ff;
  logic pend_ff;
  logic [2:0] phaseCnt_ff;
  logic [ias_pkg::CNT_W-1:0] sampleCnt_ff;
  logic [3:0] elemCnt_ff;
  logic signed [ias_pkg::SUM_W-1:0] sum_ff;
  logic [15:0] result_ff;
  logic [15:0] fmtCode;
  logic [ias_pkg::DATA_W-1:0] rdData_ff;
  logic rdErr_ff;
  logic setupPhase;
  logic wrAccess;
  logic startWrite;
  logic finish;
  logic [ias_pkg::CNT_W-1:0] smaxRun;
  logic [3:0] numConvRun;
  logic lastSample;
  logic lastElem;
  logic badCfg;
  logic addrHit;

  assign setupPhase = psel && !penable;
  assign wrAccess = psel && penable && pwrite && !pslverr;
  assign startWrite = wrAccess && paddr == ias_pkg::OFS_SETUP_ZERO &&
                      pwdata[ias_pkg::BIT_START];
  assign addrHit = paddr == ias_pkg::OFS_SETUP_ZERO || paddr == ias_pkg::OFS_RESULT_LOW ||
                   paddr == ias_pkg::OFS_RESULT_HIGH || paddr == ias_pkg::OFS_STATUS;
  // Zero-wait slave: read data was captured in the setup cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && rdErr_ff;
  assign prdata = rdData_ff;
  assign badCfg = osrCfg_ff == 3'h7 && nelCfg_ff == 2'h3;

  assign smaxRun = CNT_W'(11'h008 << osrRun_ff);
  assign numConvRun = 4'(4'h1 << nelRun_ff);
  assign lastSample = sampleCnt_ff == smaxRun;
  assign lastElem = elemCnt_ff == numConvRun - 4'h1;
  assign finish = sampleTick && state_ff == ias_pkg::ST_TERM &&
                  phaseCnt_ff == 3'(ias_pkg::N_END - 1);
  assign busy = state_ff != ias_pkg::ST_IDLE;
  assign modRun = state_ff == ias_pkg::ST_CONV && !lastSample;
  assign modClear = state_ff == ias_pkg::ST_INIT;

  // Sample clock enable: one tick every fourth peripheral clock
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      divCnt_ff <= 2'h0;
    else
      divCnt_ff <= divCnt_ff + 2'h1;
  end
  assign sampleTick = divCnt_ff == 2'(ias_pkg::SAMPLE_DIV - 1);

  // The comparator bit comes from the analog side, so it is synchronised
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      modSync1_ff <= 1'b0;
      modSync2_ff <= 1'b0;
    end
    else
    begin
      modSync1_ff <= modBit;
      modSync2_ff <= modSync1_ff;
    end
  end

  // Configuration register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      contBit_ff <= 1'b0;
      osrCfg_ff <= ias_pkg::OSR_RESET;
      nelCfg_ff <= ias_pkg::NEL_RESET;
    end
    else if (wrAccess && paddr == ias_pkg::OFS_SETUP_ZERO)
    begin
      contBit_ff <= pwdata[ias_pkg::BIT_CONT];
      osrCfg_ff <= pwdata[ias_pkg::POS_OSR +: ias_pkg::OSR_W];
      nelCfg_ff <= pwdata[ias_pkg::POS_NEL +: ias_pkg::NEL_W];
    end
  end

  // Read data is captured during the setup cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rdData_ff <= '0;
      rdErr_ff <= 1'b0;
    end
    else if (setupPhase)
    begin
      rdErr_ff <= !addrHit;
      rdData_ff <= '0;
      unique case (paddr)
        ias_pkg::OFS_SETUP_ZERO:
        begin
          rdData_ff[ias_pkg::POS_NEL +: ias_pkg::NEL_W] <= nelCfg_ff;
          rdData_ff[ias_pkg::POS_OSR +: ias_pkg::OSR_W] <= osrCfg_ff;
          rdData_ff[ias_pkg::BIT_CONT] <= contBit_ff;
        end
        ias_pkg::OFS_RESULT_LOW: rdData_ff[7:0] <= result_ff[7:0];
        ias_pkg::OFS_RESULT_HIGH: rdData_ff[7:0] <= result_ff[15:8];
        ias_pkg::OFS_STATUS:
        begin
          rdData_ff[ias_pkg::BIT_BUSY] <= busy;
          rdData_ff[ias_pkg::BIT_BAD_CFG] <= badCfg;
        end
        default: rdData_ff <= '0;
      endcase
    end
  end

  // Pending request: set by software or by continuous mode, taken at the next tick
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pend_ff <= 1'b0;
    else if (finish && contBit_ff)
      pend_ff <= 1'b1;
    else if (startWrite && !busy)
      pend_ff <= 1'b1;
    else if (sampleTick && state_ff == ias_pkg::ST_IDLE)
      pend_ff <= 1'b0;
  end

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ias_pkg::ST_IDLE: if (pend_ff) nxt_state = ias_pkg::ST_INIT;
      ias_pkg::ST_INIT:
        if (phaseCnt_ff == 3'(ias_pkg::N_INIT - 1)) nxt_state = ias_pkg::ST_CONV;
      ias_pkg::ST_CONV: if (lastSample && lastElem) nxt_state = ias_pkg::ST_TERM;
      ias_pkg::ST_TERM:
        if (phaseCnt_ff == 3'(ias_pkg::N_END - 1)) nxt_state = ias_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state_ff <= ias_pkg::ST_IDLE;
    else if (sampleTick)
      state_ff <= nxt_state;
  end

  // Phase and sample counters; config is frozen for the whole conversion
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      phaseCnt_ff <= 3'h0;
      sampleCnt_ff <= '0;
      elemCnt_ff <= 4'h0;
      osrRun_ff <= ias_pkg::OSR_RESET;
      nelRun_ff <= ias_pkg::NEL_RESET;
    end
    else if (sampleTick)
    begin
      if (nxt_state != state_ff)
        phaseCnt_ff <= 3'h0;
      else
        phaseCnt_ff <= phaseCnt_ff + 3'h1;
      if (state_ff == ias_pkg::ST_IDLE)
      begin
        osrRun_ff <= osrCfg_ff;
        nelRun_ff <= nelCfg_ff;
        elemCnt_ff <= 4'h0;
        sampleCnt_ff <= '0;
      end
      else if (state_ff == ias_pkg::ST_CONV)
      begin
        // One extra period after smax samples closes each elementary conversion
        if (lastSample)
        begin
          sampleCnt_ff <= '0;
          elemCnt_ff <= elemCnt_ff + 4'h1;
        end
        else
          sampleCnt_ff <= sampleCnt_ff + CNT_W'(1);
      end
    end
  end
  assign crossInputs = elemCnt_ff[0];

  // Crossed conversions see the input inverted, so their bits count negatively
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      sum_ff <= '0;
    else if (sampleTick && state_ff == ias_pkg::ST_INIT)
      sum_ff <= '0;
    else if (sampleTick && modRun)
    begin
      if (modSync2_ff ^ crossInputs)
        sum_ff <= sum_ff + 16'sd1;
      else
        sum_ff <= sum_ff - 16'sd1;
    end
  end

  ias_result_format u_format
  (
    .sumVal(sum_ff),
    .osrExp(osrRun_ff),
    .nelExp(nelRun_ff),
    .code(fmtCode)
  );

  // Both bytes change together, but two byte reads can straddle a completion and mix two results
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      result_ff <= ias_pkg::RESULT_RESET;
    else if (finish)
      result_ff <= fmtCode;
  end

  // Helper values for the checks below
  logic [4:0] chkRes;
  logic signed [ias_pkg::SUM_W-1:0] chkTotal;
  assign chkRes = (5'(ias_pkg::RES_BASE + 2 * int'(osrRun_ff) + int'(nelRun_ff)) > 5'd16) ?
                  5'd16 : 5'(ias_pkg::RES_BASE + 2 * int'(osrRun_ff) + int'(nelRun_ff));
  assign chkTotal = ias_pkg::SUM_W'(smaxRun) * ias_pkg::SUM_W'(numConvRun);

  property p_tick_div;
    @(posedge clk_sys) disable iff (!rst_n)
    sampleTick |=> !sampleTick [*3] ##1 sampleTick;
  endproperty
  a_tick_div: assert property (p_tick_div) else $error("sample tick not every 4 clocks");

  property p_init_len;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(modClear) |-> modClear [*8] ##12 modClear ##1 !modClear;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init phase not 5 periods");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    !finish |=> $stable(result_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed outside completion");

  property p_ignore;
    @(posedge clk_sys) disable iff (!rst_n)
    busy && startWrite && !(finish && contBit_ff) |=> !pend_ff;
  endproperty
  a_ignore: assert property (p_ignore) else $error("request taken while busy");

  property p_cont;
    @(posedge clk_sys) disable iff (!rst_n)
    finish && contBit_ff |=> !busy ##[1:8] modClear;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode did not restart");

  property p_busy_rise;
    @(posedge clk_sys) disable iff (!rst_n)
    startWrite && !busy |-> ##[1:8] busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");

  property p_alt;
    @(posedge clk_sys) disable iff (!rst_n)
    $changed(elemCnt_ff) && state_ff == ias_pkg::ST_CONV |-> crossInputs != $past(crossInputs);
  endproperty
  a_alt: assert property (p_alt) else $error("polarity did not alternate");

  property p_sign;
    @(posedge clk_sys) disable iff (!rst_n)
    finish |=> result_ff[15] == $past(sum_ff[ias_pkg::SUM_W-1]);
  endproperty
  a_sign: assert property (p_sign) else $error("result sign wrapped");

  property p_neg_fs;
    @(posedge clk_sys) disable iff (!rst_n)
    finish && sum_ff == -chkTotal |=> (result_ff >> (16 - $past(chkRes))) ==
      (ias_pkg::CODE_NEG_FS >> (16 - $past(chkRes)));
  endproperty
  a_neg_fs: assert property (p_neg_fs) else $error("negative full scale wrong");

  property p_pad;
    @(posedge clk_sys) disable iff (!rst_n)
    finish && chkRes < 5'd16 |=> result_ff[15 - $past(chkRes)] &&
      ((result_ff & ((16'h0001 << (15 - $past(chkRes))) - 16'h0001)) == 16'h0000);
  endproperty
  a_pad: assert property (p_pad) else $error("normalisation padding wrong");

  property p_stay_idle;
    @(posedge clk_sys) disable iff (!rst_n)
    !busy && !pend_ff |=> !busy;
  endproperty
  a_stay_idle: assert property (p_stay_idle) else $error("conversion began without request");

  c_one_shot: cover property (@(posedge clk_sys) disable iff (!rst_n)
    finish && !contBit_ff);
  c_cont: cover property (@(posedge clk_sys) disable iff (!rst_n)
    finish && contBit_ff);
  c_pos_fs: cover property (@(posedge clk_sys) disable iff (!rst_n)
    finish && fmtCode == ias_pkg::CODE_POS_FS);
  c_multi_elem: cover property (@(posedge clk_sys) disable iff (!rst_n)
    finish && nelRun_ff != 2'h0);
endmodule : ias_sequencer

// ===== tb/incremental_adc_sequencer_tb.sv
// Self-checking bench for the incremental converter sequencer
`timescale 1ns/100ps
module incremental_adc_sequencer_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic modBit = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, modRun, modClear, crossInputs, busy;
  logic dirBit = 1'b1;
  logic cancelMode = 1'b0;
  logic [31:0] rd;
  logic err;
  logic [15:0] res;
  logic [15:0] lastRes = 16'h0000;
  int fails = 0;
  int checked = 0;
  int n;
  int clrCnt = 0;
  int runCnt = 0;

  ias_sequencer i_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .modBit(modBit),
    .modRun(modRun),
    .modClear(modClear),
    .crossInputs(crossInputs),
    .busy(busy)
  );

  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Cancel mode holds the comparator still so crossed conversions subtract
  always @(posedge clk_sys)
  begin
    modBit <= cancelMode ? dirBit : (crossInputs ^ dirBit);
  end

  // Phase outputs are counted in clocks so each run can check their length
  always @(posedge clk_sys)
  begin
    clrCnt <= clrCnt + int'(modClear);
    runCnt <= runCnt + int'(modRun);
  end

  task automatic report_and_stop;
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask : chk_val

  task automatic chk_cnt(input int e, input int g);
    checked++;
    if (g != e)
    begin
      fails++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask : chk_cnt

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k >= 16)
    begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_busy(input logic v, input int lim);
    n = 0;
    while (busy !== v)
    begin
      @(posedge clk_sys);
      n++;
      if (n > lim)
      begin
        fails++;
        report_and_stop();
      end
    end
  endtask : wait_busy

  task automatic read_res;
    apb(1'b0, ias_pkg::OFS_RESULT_HIGH, 32'h0);
    res[15:8] = rd[7:0];
    apb(1'b0, ias_pkg::OFS_RESULT_LOW, 32'h0);
    res[7:0] = rd[7:0];
  endtask : read_res

  function automatic logic [31:0] cfg(input int oversampling_exponent, nel, input logic st, ct);
    return (32'(st) << ias_pkg::BIT_START) | (32'(nel) << ias_pkg::POS_NEL)
      | (32'(oversampling_exponent) << ias_pkg::POS_OSR) | (32'(ct) << ias_pkg::BIT_CONT);
  endfunction : cfg

  function automatic logic [15:0] exp_code(input int oversampling_exponent, nel, s);
    int v;
    int r;
    logic [15:0] c;
    v = s * (1 << (12 - oversampling_exponent - nel));
    v = (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
    c = v[15:0];
    r = 6 + 2 * oversampling_exponent + nel;
    if (r < 16)
    begin
      c = c & (16'hffff << (16 - r));
      c[15-r] = 1'b1;
    end
    return c;
  endfunction : exp_code

  function automatic int exp_sum(input int oversampling_exponent, nel, input logic dir, canc);
    int s;
    s = canc ? (((1 << nel) == 1) ? (8 << oversampling_exponent) : 0) : (1 << nel) * (8 << oversampling_exponent);
    return dir ? s : -s;
  endfunction : exp_sum

  task automatic run(input int oversampling_exponent, nel, input logic dir, canc);
    logic [15:0] e;
    int c0;
    int r0;
    e = exp_code(oversampling_exponent, nel, exp_sum(oversampling_exponent, nel, dir, canc));
    c0 = clrCnt;
    r0 = runCnt;
    dirBit <= dir;
    cancelMode <= canc;
    apb(1'b1, ias_pkg::OFS_SETUP_ZERO, cfg(oversampling_exponent, nel, 1'b1, 1'b0));
    wait_busy(1'b1, 16);
    chk_cnt(1, int'(n <= 9));
    apb(1'b1, ias_pkg::OFS_SETUP_ZERO, cfg(oversampling_exponent, nel, 1'b1, 1'b0));
    read_res();
    chk_val(32'(lastRes), 32'(res));
    wait_busy(1'b0, ((10 + (1 << nel) * ((8 << oversampling_exponent) + 1)) * 4) + 40);
    chk_cnt(ias_pkg::N_INIT * ias_pkg::SAMPLE_DIV, clrCnt - c0);
    chk_cnt((1 << nel) * (8 << oversampling_exponent) * ias_pkg::SAMPLE_DIV, runCnt - r0);
    read_res();
    chk_val(32'(e), 32'(res));
    repeat (12) @(posedge clk_sys);
    chk_val(32'h0, 32'(busy));
    lastRes = e;
  endtask : run

  task automatic run_cont(input int oversampling_exponent, nel);
    int per;
    int tgt;
    tgt = (10 + (1 << nel) * ((8 << oversampling_exponent) + 1)) * 4;
    dirBit <= 1'b0;
    cancelMode <= 1'b0;
    apb(1'b1, ias_pkg::OFS_SETUP_ZERO, cfg(oversampling_exponent, nel, 1'b1, 1'b1));
    wait_busy(1'b1, 16);
    repeat (2)
    begin
      wait_busy(1'b0, tgt);
      per = n;
      wait_busy(1'b1, tgt);
      chk_cnt(tgt, per + n);
    end
    apb(1'b1, ias_pkg::OFS_SETUP_ZERO, cfg(oversampling_exponent, nel, 1'b0, 1'b0));
    repeat (2 * tgt + 16) @(posedge clk_sys);
    chk_val(32'h0, 32'(busy));
    read_res();
    chk_val(32'(exp_code(oversampling_exponent, nel, exp_sum(oversampling_exponent, nel, 1'b0, 1'b0))), 32'(res));
    lastRes = res;
  endtask : run_cont

  initial
  begin
    void'($urandom(32'h37ba));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk_val(32'h0, rd);
      chk_val(32'h0, 32'(err));
    end
    apb(1'b1, 8'h10, 32'hffffffff);
    chk_val(32'h1, 32'(err));
    apb(1'b0, 8'h10, 32'h0);
    chk_val(32'h0, rd);
    apb(1'b1, ias_pkg::OFS_RESULT_HIGH, 32'hff);
    apb(1'b0, ias_pkg::OFS_RESULT_HIGH, 32'h0);
    chk_val(32'h0, rd);
    // Illegal pairing is only flagged, so no run is started here
    apb(1'b1, ias_pkg::OFS_SETUP_ZERO, cfg(7, 3, 1'b0, 1'b0));
    apb(1'b0, ias_pkg::OFS_STATUS, 32'h0);
    chk_val(32'h2, rd);
    apb(1'b0, ias_pkg::OFS_SETUP_ZERO, 32'h0);
    chk_val(cfg(7, 3, 1'b0, 1'b0), rd);
    run(0, 0, 1'b1, 1'b0);
    run(0, 0, 1'b0, 1'b0);
    run(3, 1, 1'b1, 1'b1);
    run(7, 0, 1'b1, 1'b0);
    run(1, 2, 1'b0, 1'b1);
    repeat (6)
      run($urandom % 4, $urandom % 4, 1'($urandom), 1'($urandom));
    run_cont(1, 1);
    report_and_stop();
  end
endmodule : incremental_adc_sequencer_tb
